// ---- design/wdm_pkg.sv ----
// Purpose: shared constants and types of the timeout monitor with alarm relay
// Assumes: 100 MHz system clock, 8-bit host port with 4-bit offset inside the card window
// Notes:   all timing counts derive from printed times and the clock period
package wdm_pkg;

  // ---------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_RELAY = 4'hd;
  localparam logic [ADDR_W-1:0] OFS_MON   = 4'he;
  localparam logic [ADDR_W-1:0] OFS_CFG   = 4'hf;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_TEMP_OK_BIT = 0;
  localparam int unsigned STAT_MON_OK_BIT  = 1;
  localparam int unsigned REL_SW_BIT       = 1;
  localparam int unsigned REL_STATE_BIT    = 0;
  localparam int unsigned CFG_SEL_HI_BIT   = 3;
  localparam int unsigned CFG_SEL_LO_BIT   = 4;
  localparam int unsigned CFG_PCRST_EN_BIT = 6;
  localparam int unsigned CFG_IRQ_EN_BIT   = 7;

  localparam logic              SW_RELAY_RST = 1'h1;
  localparam logic [DATA_W-1:0] RDATA_ZERO   = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned ONE_SEC_NS        = 1000000000;
  localparam int unsigned SEC_CYCLES        = ONE_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned FAULT_HOLD_MS     = 500;
  localparam int unsigned NS_PER_MS         = 1000000;
  localparam int unsigned FAULT_HOLD_NS     = FAULT_HOLD_MS * NS_PER_MS;
  localparam int unsigned FAULT_HOLD_CYCLES = (FAULT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PC_RESET_NS       = 10000;
  localparam int unsigned PC_RESET_CYCLES   = PC_RESET_NS / CLK_PERIOD_NS;

  localparam int unsigned PRESC_W = 27;
  localparam int unsigned HOLD_W  = 26;
  localparam int unsigned SECS_W  = 5;
  localparam int unsigned PCRST_W = 10;

  localparam logic [SECS_W-1:0] SECS_ONE     = 5'h01;
  localparam logic [SECS_W-1:0] SECS_TWO     = 5'h02;
  localparam logic [SECS_W-1:0] SECS_EIGHT   = 5'h08;
  localparam logic [SECS_W-1:0] SECS_SIXTEEN = 5'h10;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    interval_sel_one_second     = 2'b00,
    interval_sel_two_seconds    = 2'b01,
    interval_sel_eight_seconds  = 2'b10,
    interval_sel_sixteen_seconds = 2'b11
  } wdm_interval_t;

  typedef enum logic [1:0] {
    MON_IDLE    = 2'b00,
    MON_ARMED   = 2'b01,
    MON_EXPIRED = 2'b10
  } wdm_state_t;

endpackage

// ---- design/wdm_sec_tick.sv ----
// Purpose: one-second tick prescaler for the timeout monitor
// Assumes: clr restarts a full second
// Notes:   tick is a one-cycle pulse from a flop
`timescale 1ns/1ps
module wdm_sec_tick #(
  parameter int unsigned CYCLES = wdm_pkg::SEC_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick_ff
);
  import wdm_pkg::*;

  localparam logic [PRESC_W-1:0] LAST = PRESC_W'(CYCLES - 1);

  logic [PRESC_W-1:0] count_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else if (clr) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else if (count_ff == LAST) begin
      count_ff <= '0;
      tick_ff  <= 1'b1;
    end else begin
      count_ff <= count_ff + 1'b1;
      tick_ff  <= 1'b0;
    end
  end

endmodule // wdm_sec_tick

// ---- design/wdm_fault_hold.sv ----
// Purpose: fault hold timer feeding the relay drive
// Assumes: rst is power-on only; host resets never reach this counter
// Notes:   hold stays high while fault is present and CYCLES after it ends
`timescale 1ns/1ps
module wdm_fault_hold #(
  parameter int unsigned CYCLES = wdm_pkg::FAULT_HOLD_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fault,
  output logic      hold
);
  import wdm_pkg::*;

  localparam logic [HOLD_W-1:0] LOAD = HOLD_W'(CYCLES);

  logic [HOLD_W-1:0] count_ff;

  // reload while faulty, run down afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;                                    // R20
    end else if (fault) begin
      count_ff <= LOAD;                                  // R14
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign hold = fault | (count_ff != '0);                // R14

endmodule // wdm_fault_hold

// ---- design/wdm_top.sv ----
// Purpose: timeout monitor with liveness indicator and alarm relay drive
// Assumes: rst is power-on reset; pc_reset_n_pin is the host PC reset pin
// Notes:   host port offsets are relative to the card base address
//
// Overview of operation
// R1: after reset the monitor is idle and both indicator colours are dark
// R2: a write to offset 0Eh arms the monitor and lights green
// R3: every later 0Eh write restarts the interval, also after expiry
// R4: bit 1 of offset 0Eh reads the monitor health
// R5: missing the interval turns the indicator from green to red
// R6: expiry clears the health bit at offset 0Eh
// R7: expiry always drops the relay into the fail-state position
// R8: expiry resets the host PC only when enabled
// R9: expiry raises the host interrupt only when enabled
// R10: configuration bits 6 and 7 enable PC reset and interrupt
// R11: rewriting an expired monitor returns green and resumes timing
// R12: bits 3 and 4 choose 1 s, 2 s, 8 s or 16 s
// R13: changing the interval while armed restarts the timeout
// R14: a fault keeps the relay dropped for at least 500 ms
// R15: after power-on or PC reset without fault the relay is energized
// R16: expiry or over-temperature de-energizes the relay
// R17: bit 1 at offset 0Dh drops or restores the relay by software
// R18: software cannot restore the relay while a fault is present
// R19: a seconds tick times the interval; 0Eh writes and interval changes clear the counter
// R20: the hold counter is cleared only by power-on reset
`timescale 1ns/1ps
module wdm_top #(
  parameter int unsigned SEC_CYCLES_P  = wdm_pkg::SEC_CYCLES,
  parameter int unsigned HOLD_CYCLES_P = wdm_pkg::FAULT_HOLD_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [wdm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [wdm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [wdm_pkg::DATA_W-1:0]  rdata_ff,
  input  wire logic                        temp_fault_pin,
  input  wire logic                        pc_reset_n_pin,
  output logic                             liveness_indicator_green_ff,
  output logic                             liveness_indicator_red_ff,
  output logic                             relay_energize_ff,
  output logic                             host_irq_ff,
  output logic                             pc_reset_out_ff
);
  import wdm_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic temp_meta_ff;
  logic temp_fault_ff;
  logic pcrst_meta_ff;
  logic pcrst_n_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_meta_ff  <= 1'b0;
      temp_fault_ff <= 1'b0;
    end else begin
      temp_meta_ff  <= temp_fault_pin;
      temp_fault_ff <= temp_meta_ff;
    end
  end

  // host reset reads as asserted until two clean samples arrive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcrst_meta_ff <= 1'b0;
      pcrst_n_ff    <= 1'b0;
    end else begin
      pcrst_meta_ff <= pc_reset_n_pin;
      pcrst_n_ff    <= pcrst_meta_ff;
    end
  end

  logic pc_rst;

  assign pc_rst = ~pcrst_n_ff;

  // ---------------------------------------------------------------
  // host port decode
  // ---------------------------------------------------------------
  logic wr_mon;
  logic wr_cfg;
  logic wr_rel;

  assign wr_mon = wr_en & (addr == OFS_MON);
  assign wr_cfg = wr_en & (addr == OFS_CFG);
  assign wr_rel = wr_en & (addr == OFS_RELAY);

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  wdm_interval_t sel_ff;
  logic          pcrst_en_ff;
  logic          irq_en_ff;
  wdm_interval_t nxt_sel;

  assign nxt_sel = wdm_interval_t'({wdata[CFG_SEL_HI_BIT], wdata[CFG_SEL_LO_BIT]}); // R12

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_ff      <= interval_sel_one_second;
      pcrst_en_ff <= 1'b0;
      irq_en_ff   <= 1'b0;
    end else if (pc_rst) begin
      sel_ff      <= interval_sel_one_second;
      pcrst_en_ff <= 1'b0;
      irq_en_ff   <= 1'b0;
    end else if (wr_cfg) begin
      sel_ff      <= nxt_sel;                            // R12
      pcrst_en_ff <= wdata[CFG_PCRST_EN_BIT];            // R10
      irq_en_ff   <= wdata[CFG_IRQ_EN_BIT];              // R10
    end
  end

  logic [SECS_W-1:0] limit;

  always_comb begin
    unique case (sel_ff)
      interval_sel_one_second:      limit = SECS_ONE;     // R12
      interval_sel_two_seconds:     limit = SECS_TWO;     // R12
      interval_sel_eight_seconds:   limit = SECS_EIGHT;   // R12
      interval_sel_sixteen_seconds: limit = SECS_SIXTEEN; // R12
    endcase
  end

  // ---------------------------------------------------------------
  // monitor state
  // ---------------------------------------------------------------
  wdm_state_t        state_ff;
  wdm_state_t        nxt_state;
  logic              sel_change;
  logic              restart;
  logic              expire;
  logic              tick;
  logic [SECS_W-1:0] secs_ff;

  assign sel_change = wr_cfg & (nxt_sel != sel_ff) & (state_ff != MON_IDLE); // R13
  assign restart    = wr_mon | sel_change;                                   // R3 R13
  // a host reset landing on the tick cycle must not fire the options
  assign expire     = (state_ff == MON_ARMED) & tick & ~restart & ~pc_rst &
                      (secs_ff == limit - 1'b1);                             // R5

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MON_IDLE: begin
        if (wr_mon) begin
          nxt_state = MON_ARMED;                         // R2
        end
      end
      MON_ARMED: begin
        if (expire) begin
          nxt_state = MON_EXPIRED;                       // R5
        end
      end
      MON_EXPIRED: begin
        if (wr_mon) begin
          nxt_state = MON_ARMED;                         // R11
        end
      end
      default: begin
        nxt_state = MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= MON_IDLE;                              // R1
    end else if (pc_rst) begin
      state_ff <= MON_IDLE;                              // R1
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // interval timing
  // ---------------------------------------------------------------
  logic tick_clr;

  assign tick_clr = restart | pc_rst | (state_ff != MON_ARMED); // R19

  wdm_sec_tick #(
    .CYCLES (SEC_CYCLES_P)
  ) u_sec_tick (
    .clk     (clk),
    .rst     (rst),
    .clr     (tick_clr),
    .tick_ff (tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secs_ff <= '0;
    end else if (pc_rst || restart) begin
      secs_ff <= '0;                                     // R19
    end else if (state_ff == MON_ARMED && tick) begin
      secs_ff <= secs_ff + 1'b1;                         // R19
    end
  end

  // ---------------------------------------------------------------
  // liveness indicator
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      liveness_indicator_green_ff <= 1'b0;               // R1
      liveness_indicator_red_ff   <= 1'b0;               // R1
    end else begin
      liveness_indicator_green_ff <= ~pc_rst & (nxt_state == MON_ARMED);   // R2 R11
      liveness_indicator_red_ff   <= ~pc_rst & (nxt_state == MON_EXPIRED); // R5
    end
  end

  // ---------------------------------------------------------------
  // expiry reactions
  // ---------------------------------------------------------------
  // a clearing write in the expiry cycle masks expire, so the write wins and no set happens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_irq_ff <= 1'b0;
    end else if (expire && irq_en_ff) begin
      host_irq_ff <= 1'b1;                               // R9
    end else if (wr_mon || pc_rst) begin
      host_irq_ff <= 1'b0;
    end
  end

  localparam logic [PCRST_W-1:0] PCRST_LOAD = PCRST_W'(PC_RESET_CYCLES);

  logic [PCRST_W-1:0] pcrst_cnt_ff;
  logic [PCRST_W-1:0] nxt_pcrst_cnt;

  // pulse survives the host reset it causes
  always_comb begin
    nxt_pcrst_cnt = pcrst_cnt_ff;
    if (expire && pcrst_en_ff) begin
      nxt_pcrst_cnt = PCRST_LOAD;                        // R8
    end else if (pcrst_cnt_ff != '0) begin
      nxt_pcrst_cnt = pcrst_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcrst_cnt_ff    <= '0;
      pc_reset_out_ff <= 1'b0;
    end else begin
      pcrst_cnt_ff    <= nxt_pcrst_cnt;
      pc_reset_out_ff <= (nxt_pcrst_cnt != '0);          // R8
    end
  end

  // ---------------------------------------------------------------
  // relay drive
  // ---------------------------------------------------------------
  logic sw_relay_ff;
  logic fault_now;
  logic fault_hold;
  logic nxt_relay;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_relay_ff <= SW_RELAY_RST;                       // R15
    end else if (pc_rst) begin
      sw_relay_ff <= SW_RELAY_RST;                       // R15
    end else if (wr_rel) begin
      sw_relay_ff <= wdata[REL_SW_BIT];                  // R17
    end
  end

  assign fault_now = temp_fault_ff | (state_ff == MON_EXPIRED); // R16

  wdm_fault_hold #(
    .CYCLES (HOLD_CYCLES_P)
  ) u_fault_hold (
    .clk   (clk),
    .rst   (rst),
    .fault (fault_now),
    .hold  (fault_hold)
  );

  // any fault or its hold time overrides the software bit
  assign nxt_relay = sw_relay_ff & ~fault_hold;          // R7 R14 R16 R17 R18

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_energize_ff <= 1'b0;
    end else begin
      relay_energize_ff <= nxt_relay;
    end
  end

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  logic mon_ok;
  logic temp_ok;

  assign mon_ok  = (state_ff != MON_EXPIRED);            // R4 R6
  assign temp_ok = ~temp_fault_ff;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = RDATA_ZERO;
    if (rd_en) begin
      unique case (addr)
        OFS_MON: begin
          nxt_rdata[STAT_TEMP_OK_BIT] = temp_ok;
          nxt_rdata[STAT_MON_OK_BIT]  = mon_ok;              // R4 R6
        end
        OFS_RELAY: begin
          nxt_rdata[REL_SW_BIT]    = sw_relay_ff;
          nxt_rdata[REL_STATE_BIT] = relay_energize_ff;
        end
        OFS_CFG: begin
          nxt_rdata[CFG_SEL_HI_BIT]   = sel_ff[1];
          nxt_rdata[CFG_SEL_LO_BIT]   = sel_ff[0];
          nxt_rdata[CFG_PCRST_EN_BIT] = pcrst_en_ff;
          nxt_rdata[CFG_IRQ_EN_BIT]   = irq_en_ff;
        end
        default: begin
          nxt_rdata = RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= RDATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule // wdm_top

// ---- verif/wdm_top_asserts.sv ----
// Purpose: port-level checks of the timeout monitor
// Assumes: one clock domain, rst async active high
// Notes:   helper counters stand in for long waits
`timescale 1ns/1ps
module wdm_top_asserts import wdm_pkg::*; #(
  parameter int unsigned SEC_CYCLES_P  = 20,
  parameter int unsigned HOLD_CYCLES_P = 30
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [wdm_pkg::ADDR_W-1:0] addr,
  input wire logic [wdm_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [wdm_pkg::DATA_W-1:0] rdata_ff,
  input wire logic                       temp_fault_pin,
  input wire logic                       pc_reset_n_pin,
  input wire logic                       liveness_indicator_green_ff,
  input wire logic                       liveness_indicator_red_ff,
  input wire logic                       relay_energize_ff,
  input wire logic                       host_irq_ff,
  input wire logic                       pc_reset_out_ff
);
  logic [2:0]  up_sr_ff;
  int unsigned calm_ff;
  int unsigned pls_ff;
  logic        host_up;
  logic        green;
  logic        red;
  assign host_up = (&up_sr_ff) && pc_reset_n_pin;
  assign green   = liveness_indicator_green_ff;
  assign red     = liveness_indicator_red_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_sr_ff <= 3'h0;
      calm_ff  <= HOLD_CYCLES_P;
      pls_ff   <= 0;
    end else begin
      up_sr_ff <= {up_sr_ff[1:0], pc_reset_n_pin};
      // cycles since any fault was seen, saturating
      if (temp_fault_pin || red) calm_ff <= 0;
      else if (calm_ff < HOLD_CYCLES_P) calm_ff <= calm_ff + 1;
      pls_ff <= pc_reset_out_ff ? pls_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence mon_wr_s;
    wr_en && addr == OFS_MON && host_up;
  endsequence
  sequence heat_s;
    temp_fault_pin [*3];
  endsequence
  lamp_cause_a: assert property ($rose(green) |-> $past(wr_en && addr == OFS_MON))
    else $error("green lit without write");
  arm_green_a: assert property (mon_wr_s |=> green && !red)
    else $error("write did not light green");
  lamp_excl_a: assert property (!(green && red))
    else $error("both lamp colours lit");
  stat_read_a: assert property (rd_en && addr == OFS_MON |=> rdata_ff[1] == !$past(red))
    else $error("status bit wrong");
  rd_idle_a: assert property (!rd_en |=> rdata_ff == RDATA_ZERO)
    else $error("read data outside slot");
  exp_drop_a: assert property (red |=> !relay_energize_ff)
    else $error("relay on while expired");
  heat_drop_a: assert property (heat_s |=> !relay_energize_ff)
    else $error("relay on while hot");
  sw_drop_a: assert property (wr_en && addr == OFS_RELAY && !wdata[REL_SW_BIT] && host_up
    |-> ##2 !relay_energize_ff) else $error("software drop ignored");
  hold_min_a: assert property ($rose(relay_energize_ff) |-> calm_ff >= HOLD_CYCLES_P)
    else $error("fault hold too short");
  opt_cause_a: assert property ($rose(host_irq_ff) || $rose(pc_reset_out_ff) |-> red)
    else $error("option fired without expiry");
  pulse_len_a: assert property ($fell(pc_reset_out_ff) |-> pls_ff == PC_RESET_CYCLES)
    else $error("pc reset pulse length");
endmodule // wdm_top_asserts

// ---- verif/wdm_host.sv ----
// Purpose: host processor model doing port accesses
// Assumes: strobes one cycle, read data in the next cycle
// Notes:   card reset output pulls the host reset line
`timescale 1ns/1ps
module wdm_host import wdm_pkg::*; (
  input  wire logic                       clk,
  input  wire logic                       pc_reset_out_ff,
  input  wire logic [wdm_pkg::DATA_W-1:0] rdata_ff,
  output logic      [wdm_pkg::ADDR_W-1:0] addr,
  output logic      [wdm_pkg::DATA_W-1:0] wdata,
  output logic                            wr_en,
  output logic                            rd_en,
  output logic                            pc_reset_n_pin
);
  logic hold_rst = 1'b0;
  initial begin
    addr  = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  assign pc_reset_n_pin = !(pc_reset_out_ff || hold_rst);
  // address and data flip after use so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    // data stand only in this cycle; take them mid-cycle
    @(negedge clk);
    d = rdata_ff;
  endtask
endmodule // wdm_host

// ---- verif/wdm_top_bench.sv ----
// Purpose: self-checking bench of the timeout monitor
// Assumes: shortened second and hold counts
// Notes:   host accesses go through the host model tasks
`timescale 1ns/1ps
module wdm_top_bench;
  import wdm_pkg::*;
  localparam int unsigned SEC  = 20;
  localparam int unsigned HOLD = 30;
  localparam int SECS[4] = '{1, 2, 8, 16};
  localparam logic [1:0] OPTS[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              temp_fault_pin = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] rd_v;
  logic [DATA_W-1:0] cfg;
  logic              wr_en, rd_en, pc_reset_n_pin, green, red, relay, irq, pc_out;
  int                n_errors = 0;
  int                n_compared = 0;
  int                n;
  always #5 clk = ~clk;
  wdm_top #(.SEC_CYCLES_P(SEC), .HOLD_CYCLES_P(HOLD)) wdm_top_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_ff(rdata_ff), .temp_fault_pin(temp_fault_pin), .pc_reset_n_pin(pc_reset_n_pin),
    .liveness_indicator_green_ff(green), .liveness_indicator_red_ff(red),
    .relay_energize_ff(relay), .host_irq_ff(irq), .pc_reset_out_ff(pc_out));
  wdm_host wdm_host_inst (.clk(clk), .pc_reset_out_ff(pc_out), .rdata_ff(rdata_ff),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .pc_reset_n_pin(pc_reset_n_pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic host_reset();
    wdm_host_inst.hold_rst <= 1'b1;
    tick(10);
    check(relay, 0, "relay during host reset");
    wdm_host_inst.hold_rst <= 1'b0;
    tick(HOLD + 10);
    check(relay, 1, "relay after host reset");
    check({green, red}, 0, "lamps after host reset");
  endtask
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(3);
    check({green, red}, 0, "lamps idle");
    check(relay, 1, "relay after power on");
    wdm_host_inst.rd(OFS_MON, rd_v);
    check(rd_v[1:0], 2'h3, "idle status");
    wdm_host_inst.rd(4'hc, rd_v);
    check(rd_v, 8'h00, "unmapped read");
    // -----------------------------------------------
    // every interval, every option pair
    // -----------------------------------------------
    for (int i = 0; i < 4; i++) begin
      cfg = {OPTS[i][1], OPTS[i][0], 1'b0, i[0], i[1], 3'h0};
      wdm_host_inst.wr(OFS_CFG, cfg);
      wdm_host_inst.rd(OFS_CFG, rd_v);
      check(rd_v, cfg, "config readback");
      wdm_host_inst.wr(OFS_MON, 8'h5a);
      n = 0;
      while (red !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      check(n >= SECS[i] * SEC - 1 && n <= SECS[i] * SEC + 5, 1, "expiry time");
      tick(1);
      check(green, 0, "green after expiry");
      check(relay, 0, "relay after expiry");
      check(irq, OPTS[i][1], "irq option");
      check(pc_out, OPTS[i][0], "pc reset option");
      if (OPTS[i][0]) begin
        n = 0;
        while (pc_out === 1'b1 && n < 2000) begin
          @(posedge clk);
          n++;
        end
        check(n >= PC_RESET_CYCLES - 3 && n <= PC_RESET_CYCLES + 3, 1, "pc reset span");
        tick(3);
        check({green, red, irq, relay}, 1, "state after pc reset");
        wdm_host_inst.rd(OFS_CFG, rd_v);
        check(rd_v, 8'h00, "config after pc reset");
      end else begin
        wdm_host_inst.rd(OFS_MON, rd_v);
        check(rd_v[1], 0, "status after expiry");
        wdm_host_inst.wr(OFS_MON, 8'h00);
        tick(1);
        check({green, red, irq}, 3'h4, "rearm after expiry");
        host_reset();
      end
    end
    // -----------------------------------------------
    // retrigger and interval change
    // -----------------------------------------------
    wdm_host_inst.wr(OFS_CFG, 8'h00);
    wdm_host_inst.wr(OFS_MON, 8'h01);
    tick(15);
    wdm_host_inst.wr(OFS_MON, 8'h02);
    tick(15);
    check(red, 0, "retrigger restarts");
    wdm_host_inst.wr(OFS_CFG, 8'h10);
    tick(30);
    check(red, 0, "interval change restarts");
    tick(15);
    check(red, 1, "expiry after change");
    host_reset();
    // -----------------------------------------------
    // software relay and temperature fault
    // -----------------------------------------------
    wdm_host_inst.wr(OFS_RELAY, 8'h00);
    tick(3);
    check(relay, 0, "software drop");
    wdm_host_inst.rd(OFS_RELAY, rd_v);
    check(rd_v[1], 0, "software bit");
    wdm_host_inst.wr(OFS_RELAY, 8'h02);
    tick(3);
    check(relay, 1, "software restore");
    temp_fault_pin <= 1'b1;
    tick(5);
    check(relay, 0, "relay on heat");
    wdm_host_inst.rd(OFS_MON, rd_v);
    check(rd_v[0], 0, "temperature bit");
    wdm_host_inst.wr(OFS_RELAY, 8'h02);
    tick(3);
    check(relay, 0, "restore refused");
    temp_fault_pin <= 1'b0;
    tick(10);
    check(relay, 0, "relay in hold");
    tick(HOLD);
    check(relay, 1, "relay after hold");
    give_verdict();
  end
endmodule // wdm_top_bench
bind wdm_top wdm_top_asserts #(.SEC_CYCLES_P(SEC_CYCLES_P), .HOLD_CYCLES_P(HOLD_CYCLES_P))
  chk_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata_ff(rdata_ff), .temp_fault_pin(temp_fault_pin), .pc_reset_n_pin(pc_reset_n_pin),
  .liveness_indicator_green_ff(liveness_indicator_green_ff),
  .liveness_indicator_red_ff(liveness_indicator_red_ff), .relay_energize_ff(relay_energize_ff),
  .host_irq_ff(host_irq_ff), .pc_reset_out_ff(pc_reset_out_ff));
